// *** smi_gate_pkg.sv ***
// Constants shared by the management interrupt gating block.
package smi_gate_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_STS_PERIPH = 8'h10;
    localparam logic [7:0] IDX_STS_MISC   = 8'h11;
    localparam logic [7:0] IDX_STS_PORT2  = 8'h12;
    localparam logic [7:0] IDX_STS_PORT34 = 8'h13;
    localparam logic [7:0] IDX_STS_PORT5  = 8'h14;
    localparam logic [7:0] IDX_STS_PORT1  = 8'h15;
    localparam logic [7:0] IDX_EN_PERIPH_A = 8'h16;
    localparam logic [7:0] IDX_EN_PERIPH_B = 8'h17;
    localparam logic [7:0] IDX_EN_PORT2    = 8'h18;
    localparam logic [7:0] IDX_EN_PORT34   = 8'h19;
    localparam logic [7:0] IDX_EN_PORT5    = 8'h1a;
    localparam logic [7:0] IDX_EN_PORT1    = 8'h1b;

    localparam int         NUM_EN      = 6;
    localparam int         NUM_STICKY  = 5;
    localparam logic [7:0] REG_RESET   = 8'h00;
    // Writable bits of the first enable register; bits 0, 5 and 6 reserved.
    localparam logic [7:0] EN_A_MASK   = 8'h9e;
    // Source gates of the second enable register; bits 6 and 7 are routes.
    localparam logic [7:0] EN_B_SRC    = 8'h3f;
    localparam int         ROUTE_SERIAL = 6;
    localparam int         ROUTE_PIN    = 7;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HRESP_OKAY    = 2'b00;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WR   = 2'b01,
        BUS_RDW  = 2'b10,
        BUS_RD   = 2'b11
    } bus_state_e;

endpackage

// *** mgmt_pin_sync.sv ***
// Three-stage synchroniser with agreement filter and change pulse.
module mgmt_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] chg
);
    import smi_gate_pkg::*;

    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, chg_q;
    logic [W-1:0] lvl_d, chg_d;

    // A new level is taken only when the second and third stages agree.
    always_comb begin
        lvl_d = lvl_q;
        chg_d = '0;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i] && s3_q[i] != lvl_q[i]) begin
                lvl_d[i] = s3_q[i];
                chg_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
            chg_q <= '0;
        end else begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
            chg_q <= chg_d;
        end
    end

    assign lvl = lvl_q;
    assign chg = chg_q;
endmodule // mgmt_pin_sync

// *** mgmt_w1c_flags.sv ***
// Sticky event flags, cleared by writing one; a set beats a clear.
module mgmt_w1c_flags #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    import smi_gate_pkg::*;

    logic [W-1:0] flags_q, flags_d;

    always_comb begin
        flags_d = (flags_q & ~clr) | set;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
endmodule // mgmt_w1c_flags

// *** smi_source_gating.sv ***
// Management interrupt source gating with status, enables and routing.
//
// The implementer's own choice: register access over AHB-Lite.

// What this block does
// - Status 0x15 bits 0 to 7 hold port1 pin 0 to 7 events; reset 0x00.
// - Writing one to a sticky status bit clears that bit and leaves the others.
// - Enable A: b1 printer, b2 serial2, b3 serial1, b4 floppy, b7 watchdog.
// - Enable B bits 0-5: mouse, keyboard, bus, ring1, port1 pin2, ring2.
// - Enable B also gates the combined interrupt onto the pin and the stream.
// - Enable port2: port2 bits 0-2, port6 bit 0, port2 bits 4-7 on bits 0-7.
// - Enable port3/4: port3 b0-3, port4 b1, fan sense, port4 b3, port6 b1.
// - Enable port5: port5 bits 0 to 7 in ascending order.
// - Printer, serial, floppy, mouse, keyboard flags follow their source.
// - Bits 2 to 5 of the second status register clear on a write of one.
module smi_source_gating (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic      [31:0] HRDATA,
    output logic      [1:0]  HRESP,
    input  wire logic        PRINTER_IRQ,
    input  wire logic        SERIAL2_IRQ,
    input  wire logic        SERIAL1_IRQ,
    input  wire logic        FLOPPY_IRQ,
    input  wire logic        WATCHDOG_IRQ,
    input  wire logic        MOUSE_IRQ,
    input  wire logic        KEYBOARD_IRQ,
    input  wire logic        MGMT_BUS_IRQ,
    input  wire logic        RING_ONE_N,
    input  wire logic        RING_TWO_N,
    input  wire logic        FAN_SPEED_SENSE,
    input  wire logic [7:0]  PORT1_PINS,
    input  wire logic [7:0]  PORT2_PINS,
    input  wire logic [3:0]  PORT3_PINS,
    input  wire logic [3:0]  PORT4_PINS,
    input  wire logic [7:0]  PORT5_PINS,
    input  wire logic [1:0]  PORT6_PINS,
    output logic             COMBINED_MGMT_IRQ_N,
    output logic             MGMT_IRQ_PIN_N,
    output logic             SERIAL_IRQ_REQ
);
    import smi_gate_pkg::*;

    localparam int NRAW = 45;

    function automatic logic hit_idx(input logic [7:0] word,
                                     input logic       ok,
                                     input logic [7:0] idx);
        hit_idx = ok && (word == idx);
    endfunction

    // Synchronised levels and change pulses of every outside input.
    logic [NRAW-1:0] raw;
    logic [NRAW-1:0] lvl;
    logic [NRAW-1:0] chg;
    logic [1:0]      p6_l;
    logic [1:0]      p6_c;
    logic [7:0]      p5_l;
    logic [7:0]      p5_c;
    logic [7:0]      p2_l;
    logic [7:0]      p2_c;
    logic [7:0]      p1_l;
    logic [7:0]      p1_c;
    logic [3:0]      p4_l;
    logic [3:0]      p4_c;
    logic [3:0]      p3_l;
    logic [3:0]      p3_c;
    logic            fan_l;
    logic            fan_c;
    logic [1:0]      ring_l;
    logic [1:0]      ring_c;
    logic            smb_l;
    logic            smb_c;
    logic [6:0]      per_l;
    logic [6:0]      per_c;

    assign raw = {PORT6_PINS, PORT5_PINS, PORT4_PINS, PORT3_PINS,
                  FAN_SPEED_SENSE, PORT2_PINS, PORT1_PINS,
                  RING_TWO_N, RING_ONE_N, MGMT_BUS_IRQ,
                  KEYBOARD_IRQ, MOUSE_IRQ, WATCHDOG_IRQ, FLOPPY_IRQ,
                  SERIAL1_IRQ, SERIAL2_IRQ, PRINTER_IRQ};

    mgmt_pin_sync #(.W(NRAW)) u_sync (
        .clk  (CLK),
        .nrst (NRST),
        .raw  (raw),
        .lvl  (lvl),
        .chg  (chg)
    );

    assign {p6_l, p5_l, p4_l, p3_l, fan_l, p2_l, p1_l,
            ring_l, smb_l, per_l} = lvl;
    assign {p6_c, p5_c, p4_c, p3_c, fan_c, p2_c, p1_c,
            ring_c, smb_c, per_c} = chg;

    // Bus address and data phase tracking.
    bus_state_e  st_q;
    bus_state_e  st_d;
    logic [7:0]  word_q;
    logic [7:0]  word_d;
    logic        ok_q;
    logic        ok_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        take;
    logic        wr_now;

    assign take   = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign wr_now = (st_q == BUS_WR);

    // Enable registers.
    logic [7:0] en_q [NUM_EN];
    logic [7:0] en_d [NUM_EN];

    always_comb begin
        for (int i = 0; i < NUM_EN; i++) begin
            en_d[i] = en_q[i];
            if (wr_now && hit_idx(word_q, ok_q,
                                  8'(IDX_EN_PERIPH_A + 8'(i)))) begin
                en_d[i] = (i == 0) ? (HWDATA[7:0] & EN_A_MASK)
                                   : HWDATA[7:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            for (int i = 0; i < NUM_EN; i++) begin
                en_q[i] <= REG_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_EN; i++) begin
                en_q[i] <= en_d[i];
            end
        end
    end

    // Level status that follows its source; writes have no effect.
    logic [7:0] sts_periph;
    assign sts_periph = {per_l[4], 2'b00, per_l[3], per_l[2],
                         per_l[1], per_l[0], 1'b0};

    // Sticky status registers: misc, port2, port3/4, port5, port1.
    logic [7:0] set_v [NUM_STICKY];
    logic [7:0] clr_v [NUM_STICKY];
    logic [7:0] flg_v [NUM_STICKY];

    // Ring inputs are active low, so their event is the falling level.
    assign set_v[0] = {2'b00, ring_c[1] & ~ring_l[1], p1_c[2] & p1_l[2],
                       ring_c[0] & ~ring_l[0], smb_c & smb_l, 2'b00};
    assign set_v[1] = {p2_c[7:4] & p2_l[7:4], p6_c[0] & p6_l[0],
                       p2_c[2:0] & p2_l[2:0]};
    assign set_v[2] = {p6_c[1] & p6_l[1], p4_c[3] & p4_l[3],
                       fan_c & fan_l, p4_c[1] & p4_l[1],
                       p3_c & p3_l};
    assign set_v[3] = p5_c & p5_l;
    assign set_v[4] = p1_c & p1_l;

    // One write-one clear strobe per sticky register, taken in the data
    // phase while HWDATA stands.
    generate
        for (genvar g = 0; g < NUM_STICKY; g++) begin : g_sticky
            assign clr_v[g] = (wr_now && hit_idx(word_q, ok_q,
                               8'(IDX_STS_MISC + 8'(g))))
                              ? HWDATA[7:0] : 8'h00;
            mgmt_w1c_flags #(.W(8)) u_flags (
                .clk   (CLK),
                .nrst  (NRST),
                .set   (set_v[g]),
                .clr   (clr_v[g]),
                .flags (flg_v[g])
            );
        end
    endgenerate

    // Second status register: mouse and keyboard follow their source.
    logic [7:0] sts_misc;
    assign sts_misc = {flg_v[0][7:2], per_l[6], per_l[5]};

    // Gating of each source by its enable bit.
    logic hit;
    assign hit = |(sts_periph & en_q[0])
               | |(sts_misc & en_q[1] & EN_B_SRC)
               | |(flg_v[1] & en_q[2])
               | |(flg_v[2] & en_q[3])
               | |(flg_v[3] & en_q[4])
               | |(flg_v[4] & en_q[5]);

    // Registered interrupt outputs and their routes.
    logic comb_q;
    logic comb_d;
    logic pin_q;
    logic pin_d;
    logic ser_q;
    logic ser_d;

    always_comb begin
        comb_d = hit;
        pin_d  = hit && en_q[1][ROUTE_PIN];
        ser_d  = hit && en_q[1][ROUTE_SERIAL];
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            comb_q <= 1'b0;
            pin_q  <= 1'b0;
            ser_q  <= 1'b0;
        end else begin
            comb_q <= comb_d;
            pin_q  <= pin_d;
            ser_q  <= ser_d;
        end
    end

    assign COMBINED_MGMT_IRQ_N = ~comb_q;
    assign MGMT_IRQ_PIN_N      = ~pin_q;
    assign SERIAL_IRQ_REQ      = ser_q;

    // Read multiplexer, sampled after any earlier write has landed.
    logic [7:0] rd_byte;

    always_comb begin
        if (hit_idx(word_q, ok_q, IDX_STS_PERIPH)) begin
            rd_byte = sts_periph;
        end else if (hit_idx(word_q, ok_q, IDX_STS_MISC)) begin
            rd_byte = sts_misc;
        end else if (hit_idx(word_q, ok_q, IDX_STS_PORT2)) begin
            rd_byte = flg_v[1];
        end else if (hit_idx(word_q, ok_q, IDX_STS_PORT34)) begin
            rd_byte = flg_v[2];
        end else if (hit_idx(word_q, ok_q, IDX_STS_PORT5)) begin
            rd_byte = flg_v[3];
        end else if (hit_idx(word_q, ok_q, IDX_STS_PORT1)) begin
            rd_byte = flg_v[4];
        end else if (hit_idx(word_q, ok_q, IDX_EN_PERIPH_A)) begin
            rd_byte = en_q[0];
        end else if (hit_idx(word_q, ok_q, IDX_EN_PERIPH_B)) begin
            rd_byte = en_q[1];
        end else if (hit_idx(word_q, ok_q, IDX_EN_PORT2)) begin
            rd_byte = en_q[2];
        end else if (hit_idx(word_q, ok_q, IDX_EN_PORT34)) begin
            rd_byte = en_q[3];
        end else if (hit_idx(word_q, ok_q, IDX_EN_PORT5)) begin
            rd_byte = en_q[4];
        end else if (hit_idx(word_q, ok_q, IDX_EN_PORT1)) begin
            rd_byte = en_q[5];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Writes finish with no wait; reads insert one wait cycle.
    always_comb begin
        st_d    = st_q;
        word_d  = word_q;
        ok_d    = ok_q;
        rdata_d = rdata_q;
        case (st_q)
            BUS_RDW: begin
                rdata_d = {24'h000000, rd_byte};
                st_d    = BUS_RD;
            end
            default: begin
                if (take) begin
                    word_d = HADDR[9:2];
                    ok_d   = (HADDR[31:10] == 22'h000000) &&
                             (HADDR[1:0] == 2'b00);
                    st_d   = HWRITE ? BUS_WR : BUS_RDW;
                end else begin
                    st_d   = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_q    <= BUS_IDLE;
            word_q  <= 8'h00;
            ok_q    <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            st_q    <= st_d;
            word_q  <= word_d;
            ok_q    <= ok_d;
            rdata_q <= rdata_d;
        end
    end

    assign HREADYOUT = (st_q != BUS_RDW);
    assign HRDATA    = rdata_q;
    assign HRESP     = HRESP_OKAY;
endmodule // smi_source_gating

// *** smi_gate_properties.sv ***
// Bus and interrupt output properties of the management interrupt gating.
module smi_gate_properties (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic [31:0] HRDATA,
    input wire logic [1:0]  HRESP,
    input wire logic        COMBINED_MGMT_IRQ_N,
    input wire logic        MGMT_IRQ_PIN_N,
    input wire logic        SERIAL_IRQ_REQ
);
    timeunit 1ns;
    timeprecision 1ps;
    wire take = HSEL && HREADY && HTRANS == 2'b10;
    wire rd_take = take && !HWRITE;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    sequence s_rd_answer;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    property p_rd_wait;
        rd_take |=> s_rd_answer;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    property p_wr_zero_wait;
        take && HWRITE |=> HREADYOUT;
    endproperty
    a_wr_zero_wait: assert property (p_wr_zero_wait)
        else $error("write data phase stalled");
    property p_resp_okay;
        HRESP == 2'b00;
    endproperty
    a_resp_okay: assert property (p_resp_okay)
        else $error("response not okay");
    property p_rdata_upper;
        HRDATA[31:8] == 24'h0;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper)
        else $error("read data upper bits set");
    property p_rdata_hold;
        $changed(HRDATA) |-> $past(rd_take, 2);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    property p_pin_route;
        !MGMT_IRQ_PIN_N |-> !COMBINED_MGMT_IRQ_N;
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("pin interrupt without combined interrupt");
    property p_serial_route;
        SERIAL_IRQ_REQ |-> !COMBINED_MGMT_IRQ_N || !$past(COMBINED_MGMT_IRQ_N);
    endproperty
    a_serial_route: assert property (p_serial_route)
        else $error("serial request without combined interrupt");
    property p_reset_idle;
        $rose(NRST) |-> COMBINED_MGMT_IRQ_N && MGMT_IRQ_PIN_N &&
                        !SERIAL_IRQ_REQ;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("interrupt active after reset");
endmodule // smi_gate_properties

// *** host_irq_sink.sv ***
// Host-side receiver that counts interrupts arriving on the dedicated pin.
module host_irq_sink (
    input  wire logic       clk,
    input  wire logic       pin_n,
    output logic      [7:0] pin_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pin_q = 1'b1;
    logic [7:0] cnt_q = 8'h00;
    always @(posedge clk) begin
        if (pin_q && !pin_n) begin
            cnt_q <= cnt_q + 8'h01;
        end
        pin_q <= pin_n;
    end
    assign pin_cnt = cnt_q;
endmodule // host_irq_sink

// *** smi_source_gating_tb.sv ***
// Self-checking bench for the management interrupt gating block.
module smi_source_gating_tb;
    import smi_gate_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        HWRITE = 1'b0;
    logic [1:0]  HTRANS = 2'b00;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [6:0]  lvl = 7'h00;
    logic        bus_irq = 1'b0;
    logic        ring1_n = 1'b1;
    logic        fan = 1'b0;
    logic [7:0]  p1 = 8'h00;
    logic [7:0]  p2 = 8'h00;
    logic [3:0]  p4 = 4'h0;
    logic [7:0]  p5 = 8'h00;
    logic [1:0]  p6 = 2'b00;
    logic        ring2_n = 1'b1;
    logic [3:0]  p3 = 4'h0;
    logic        HREADYOUT;
    logic        irq_n;
    logic        pin_n;
    logic        ser;
    logic [31:0] HRDATA;
    logic [31:0] rdata;
    logic [7:0]  pin_cnt;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #5 CLK = ~CLK;
    smi_source_gating dut (.CLK, .NRST, .HSEL(1'b1), .HADDR, .HTRANS,
        .HWRITE, .HSIZE(3'b010), .HWDATA, .HREADY(HREADYOUT), .HREADYOUT,
        .HRDATA, .HRESP(), .PRINTER_IRQ(lvl[0]), .SERIAL2_IRQ(lvl[1]),
        .SERIAL1_IRQ(lvl[2]), .FLOPPY_IRQ(lvl[3]), .WATCHDOG_IRQ(lvl[4]),
        .MOUSE_IRQ(lvl[5]), .KEYBOARD_IRQ(lvl[6]), .MGMT_BUS_IRQ(bus_irq),
        .RING_ONE_N(ring1_n), .RING_TWO_N(ring2_n), .FAN_SPEED_SENSE(fan),
        .PORT1_PINS(p1), .PORT2_PINS(p2), .PORT3_PINS(p3),
        .PORT4_PINS(p4), .PORT5_PINS(p5), .PORT6_PINS(p6),
        .COMBINED_MGMT_IRQ_N(irq_n), .MGMT_IRQ_PIN_N(pin_n),
        .SERIAL_IRQ_REQ(ser));
    host_irq_sink host (.clk(CLK), .pin_n(pin_n), .pin_cnt(pin_cnt));
    task stop_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge CLK);
        HTRANS <= 2'b10;
        HADDR <= {22'h0, idx, 2'b00};
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= {24'h0, d};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rdata = HRDATA;
    endtask
    task rdc(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), rdata, {24'h0, e});
    endtask
    task wr_settle(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        repeat (3) @(posedge CLK);
    endtask
    initial begin
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        for (int i = 'h10; i <= 'h1b; i++) begin
            rdc(8'(i), 8'h00);
        end
        rdc(8'h40, 8'h00);
        for (int i = 'h16; i <= 'h1a; i++) begin
            bus(1'b1, 8'(i), 8'hff);
            rdc(8'(i), i == 'h16 ? 8'h9e : 8'hff);
            bus(1'b1, 8'(i), 8'h00);
        end
        p1 <= 8'ha5;
        repeat (8) @(posedge CLK);
        rdc(8'h15, 8'ha5);
        chk("irq blocked", irq_n, 1);
        p1 <= 8'h00;
        bus(1'b1, 8'h15, 8'h05);
        rdc(8'h15, 8'ha0);
        bus(1'b1, 8'h1b, 8'h20);
        wr_settle(8'h17, 8'h80);
        chk("pin route", {irq_n, pin_n, ser}, 3'b000);
        wr_settle(8'h17, 8'h40);
        chk("serial route", {irq_n, pin_n, ser}, 3'b011);
        wr_settle(8'h15, 8'h20);
        chk("irq cleared", {irq_n, pin_n, ser}, 3'b110);
        lvl <= 7'h7f;
        repeat (8) @(posedge CLK);
        rdc(8'h10, 8'h9e);
        rdc(8'h11, 8'h13);
        wr_settle(8'h16, 8'h02);
        chk("printer irq", {irq_n, pin_n, ser}, 3'b011);
        bus(1'b1, 8'h10, 8'hff);
        rdc(8'h10, 8'h9e);
        lvl <= 7'h00;
        repeat (8) @(posedge CLK);
        rdc(8'h10, 8'h00);
        {bus_irq, ring1_n, ring2_n, fan, p2, p3, p4, p5, p6} <=
            {4'b1001, 8'h10, 4'h5, 4'ha, 8'h81, 2'b11};
        repeat (8) @(posedge CLK);
        bus_irq <= 1'b0;
        repeat (8) @(posedge CLK);
        rdc(8'h11, 8'h3c);
        bus(1'b1, 8'h11, 8'h14);
        rdc(8'h11, 8'h28);
        rdc(8'h12, 8'h18);
        rdc(8'h13, 8'hf5);
        rdc(8'h14, 8'h81);
        wr_settle(8'h1a, 8'h01);
        chk("port5 irq", {irq_n, pin_n, ser}, 3'b011);
        chk("host pin events", pin_cnt, 1);
        stop_test();
    end
endmodule // smi_source_gating_tb
bind smi_source_gating smi_gate_properties u_props (.CLK, .NRST, .HSEL,
    .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRDATA, .HRESP,
    .COMBINED_MGMT_IRQ_N, .MGMT_IRQ_PIN_N, .SERIAL_IRQ_REQ);
